// File: qec_map.vh
// Register map, field positions and timing constants of the encoder counter
`ifndef QEC_MAP_VH
`define QEC_MAP_VH

// ----------------------------------------
// Port offsets
// ----------------------------------------
`define QEC_OFS_MODE1      4'h0
`define QEC_OFS_MODE3      4'h2
`define QEC_OFS_LATCH1     4'h3
`define QEC_OFS_LATCH3     4'h5
`define QEC_OFS_OVF_HOLD   4'h6
`define QEC_OFS_CLEAR      4'h7
`define QEC_OFS_CLK_CASC   4'h8
`define QEC_OFS_TMR_BASE   4'h9
`define QEC_OFS_TMR_DIV    4'ha
`define QEC_OFS_NONE       4'hb
`define QEC_OFS_IC_PEND    4'hc
`define QEC_OFS_IC_MASK    4'hd
`define QEC_OFS_STATUS     4'he
`define QEC_OFS_IC_ACK     4'hf
`define QEC_SUB_HIGH       2'h2
`define QEC_SUB_OVF        2'h3
`define QEC_OVF_BIT        7

// ----------------------------------------
// Field codes
// ----------------------------------------
`define QEC_MODE_OFF       3'h0
`define QEC_MODE_X1        3'h1
`define QEC_MODE_X2        3'h2
`define QEC_MODE_X4        3'h3
`define QEC_MODE_TWO_PULSE 3'h4
`define QEC_MODE_ONE_PULSE 3'h5
`define QEC_MODE_CASCADE   3'h7
`define QEC_LSRC_SW        3'h0
`define QEC_LSRC_INDEX     3'h1
`define QEC_LSRC_DI0       3'h2
`define QEC_LSRC_DI1       3'h3
`define QEC_LSRC_TIMER     3'h4
`define QEC_CASC_48        2'h1
`define QEC_RST_START      24'h00_0000
`define QEC_RST_MID        24'h80_0000
`define QEC_CNT_MAX        24'hff_ffff
`define QEC_IC_MASK_RST    8'hff
`define QEC_IC_VEC_BASE    8'h08

// ----------------------------------------
// Timing
// ----------------------------------------
`define QEC_CLK_NS         5
`define QEC_TICK_NS        100000
`define QEC_SAMP_8M_NS     125
`endif

// File: qec_sync.v
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module qec_sync #(
  parameter WIDTH = 1
) (
  input  wire             ref_clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;

  always @(posedge ref_clk) begin
    if (rst) begin
      meta_q   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_q   <= pin_in;
      sync_out <= meta_q;
    end
  end
endmodule // qec_sync

// File: qec_chan.v
// One 24-bit counter channel with input decoding and overflow handling
`timescale 1ns/1ps
`include "qec_map.vh"
module qec_chan (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        samp,
  input  wire        enc_a,
  input  wire        enc_b,
  input  wire [2:0]  input_mode_sel,
  input  wire        reset_value_sel,
  input  wire        wrap_en,
  input  wire        clr,
  input  wire        casc_en,
  input  wire        casc_up,
  input  wire        casc_dn,
  input  wire        ovf_clr,
  output reg  [23:0] count_q,
  output reg         overflow_seen,
  output reg         carry_up,
  output reg         carry_dn
);
  reg        pa_q;
  reg        pb_q;
  reg        up;
  reg        dn;
  wire       ea = samp & (enc_a ^ pa_q);
  wire       eb = samp & (enc_b ^ pb_q);
  wire       ra = ea & enc_a;
  wire       rb = eb & enc_b;
  wire       wrap_hi = up & (count_q == `QEC_CNT_MAX);
  wire       wrap_lo = dn & (count_q == `QEC_RST_START);
  wire       ovf = wrap_hi | wrap_lo;
  wire [23:0] rst_val = reset_value_sel ? `QEC_RST_MID : `QEC_RST_START;

  // ----------------------------------------
  // Count direction decode
  // ----------------------------------------
  always @* begin
    up = 1'b0;
    dn = 1'b0;
    if (casc_en) begin
      up = casc_up;
      dn = casc_dn;
    end else begin
      case (input_mode_sel)
        `QEC_MODE_X1: begin
          up = ra & ~enc_b;
          dn = ra & enc_b;
        end
        `QEC_MODE_X2: begin
          up = ea & (enc_a ^ enc_b);
          dn = ea & ~(enc_a ^ enc_b);
        end
        `QEC_MODE_X4: begin
          up = (ea & (enc_a ^ enc_b)) | (eb & ~(enc_a ^ enc_b));
          dn = (ea & ~(enc_a ^ enc_b)) | (eb & (enc_a ^ enc_b));
        end
        `QEC_MODE_TWO_PULSE: begin
          up = ra;
          dn = rb;
        end
        `QEC_MODE_ONE_PULSE: begin
          // B low counts up, B high counts down
          up = ra & ~enc_b;
          dn = ra & enc_b;
        end
        default: begin
          up = 1'b0;
          dn = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Counter and flags
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      pa_q          <= 1'b0;
      pb_q          <= 1'b0;
      count_q       <= `QEC_RST_START;
      overflow_seen <= 1'b0;
      carry_up      <= 1'b0;
      carry_dn      <= 1'b0;
    end else begin
      if (samp) begin
        pa_q <= enc_a;
        pb_q <= enc_b;
      end
      carry_up <= wrap_hi & wrap_en;
      carry_dn <= wrap_lo & wrap_en;
      if (clr)
        count_q <= rst_val;
      else if (ovf & ~wrap_en)
        count_q <= count_q;
      else if (up)
        count_q <= count_q + 24'h00_0001;
      else if (dn)
        count_q <= count_q - 24'h00_0001;
      // Overflow set wins over a flag-read clear in the same cycle; a counter clear wins over the set
      if (ovf & ~clr)
        overflow_seen <= 1'b1;
      else if (ovf_clr | clr)
        overflow_seen <= 1'b0;
    end
  end
endmodule // qec_chan

// File: qec_top.v
// Three-channel encoder counter with byte port map, timer and interrupts
`timescale 1ns/1ps
`include "qec_map.vh"
module qec_top #(
  parameter TICK_CYCLES = `QEC_TICK_NS / `QEC_CLK_NS,
  parameter SAMP_CYCLES = `QEC_SAMP_8M_NS / `QEC_CLK_NS
) (
  input  wire       ref_clk,
  input  wire       rst,
  input  wire [3:0] io_addr,
  input  wire [7:0] io_wdata,
  input  wire       io_wr,
  input  wire       io_rd,
  output reg  [7:0] io_rdata,
  input  wire [2:0] enc_a,
  input  wire [2:0] enc_b,
  input  wire [2:0] enc_index,
  input  wire       digital_in_zero,
  input  wire       digital_in_one,
  output reg        irq_q
);
  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  wire [10:0] pins_s;
  wire [2:0]  a_s   = pins_s[2:0];
  wire [2:0]  b_s   = pins_s[5:3];
  wire [2:0]  idx_s = pins_s[8:6];
  wire        di0_s = pins_s[9];
  wire        di1_s = pins_s[10];

  qec_sync #(
    .WIDTH (11)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .pin_in   ({digital_in_one, digital_in_zero, enc_index, enc_b, enc_a}),
    .sync_out (pins_s)
  );

  reg  [4:0] lvl_q;
  wire [4:0] rise = {di1_s, di0_s, idx_s} & ~lvl_q;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  reg [11:0] mode_q;
  reg [11:0] latch_q;
  reg [2:0]  hold_q;
  reg [3:0]  clkcasc_q;
  reg [3:0]  tbase_q;
  reg [7:0]  tdiv_q;
  reg [7:0]  ic_pend_q;
  reg [7:0]  ic_mask_q;
  reg [2:0]  clr_q;

  wire wr_mode  = io_wr & (io_addr <= `QEC_OFS_MODE3);
  wire wr_latch = io_wr & (io_addr >= `QEC_OFS_LATCH1) & (io_addr <= `QEC_OFS_LATCH3);
  // Two-bit slot index, so offsets 4 and 5 wrap round to slots 1 and 2
  wire [1:0] lat_idx = io_addr[1:0] - 2'h3;

  always @(posedge ref_clk) begin
    if (rst) begin
      mode_q    <= 12'h000;
      latch_q   <= 12'h000;
      hold_q    <= 3'h0;
      clkcasc_q <= 4'h0;
      tbase_q   <= 4'h0;
      tdiv_q    <= 8'h00;
      ic_mask_q <= `QEC_IC_MASK_RST;
      lvl_q     <= 5'h00;
    end else begin
      lvl_q <= {di1_s, di0_s, idx_s};
      if (wr_mode)
        mode_q[io_addr[1:0]*4 +: 4] <= io_wdata[3:0];
      if (wr_latch)
        latch_q[lat_idx*4 +: 4] <= io_wdata[3:0];
      if (io_wr & (io_addr == `QEC_OFS_OVF_HOLD))
        hold_q <= io_wdata[2:0];
      if (io_wr & (io_addr == `QEC_OFS_CLK_CASC))
        clkcasc_q <= io_wdata[3:0];
      if (io_wr & (io_addr == `QEC_OFS_TMR_BASE))
        tbase_q <= io_wdata[3:0];
      if (io_wr & (io_addr == `QEC_OFS_TMR_DIV))
        tdiv_q <= io_wdata;
      if (io_wr & (io_addr == `QEC_OFS_IC_MASK))
        ic_mask_q <= io_wdata;
    end
  end

  // Counter reset strobes are one cycle wide
  always @(posedge ref_clk) begin
    if (rst)
      clr_q <= 3'h0;
    else if (io_wr & (io_addr == `QEC_OFS_CLEAR))
      clr_q <= io_wdata[2:0];
    else
      clr_q <= 3'h0;
  end

  // ----------------------------------------
  // Sample strobe from selected count clock
  // ----------------------------------------
  reg  [7:0] samp_cnt_q;
  reg        samp_q;
  wire [7:0] samp_lim = (clkcasc_q[1:0] == 2'h0) ? SAMP_CYCLES[7:0] :
                        (clkcasc_q[1:0] == 2'h1) ? SAMP_CYCLES[6:0] * 8'h02 :
                                                   SAMP_CYCLES[5:0] * 8'h04;

  always @(posedge ref_clk) begin
    if (rst) begin
      samp_cnt_q <= 8'h00;
      samp_q     <= 1'b0;
    end else if (samp_cnt_q + 8'h01 >= samp_lim) begin
      samp_cnt_q <= 8'h00;
      samp_q     <= 1'b1;
    end else begin
      samp_cnt_q <= samp_cnt_q + 8'h01;
      samp_q     <= 1'b0;
    end
  end

  // ----------------------------------------
  // Timer: tick, decade base, divider
  // ----------------------------------------
  reg  [15:0] tick_cnt_q;
  reg  [13:0] base_cnt_q;
  reg  [7:0]  div_cnt_q;
  reg         timer_pulse;
  reg  [13:0] base_lim;
  wire        tick = (tick_cnt_q == TICK_CYCLES[15:0] - 16'h0001);

  always @* begin
    case (tbase_q[2:0])
      3'h0:    base_lim = 14'h0001;
      3'h1:    base_lim = 14'h000a;
      3'h2:    base_lim = 14'h0064;
      3'h3:    base_lim = 14'h03e8;
      3'h4:    base_lim = 14'h2710;
      default: base_lim = 14'h0000;
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      tick_cnt_q  <= 16'h0000;
      base_cnt_q  <= 14'h0000;
      div_cnt_q   <= 8'h00;
      timer_pulse <= 1'b0;
    end else begin
      timer_pulse <= 1'b0;
      tick_cnt_q  <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
      // Divider of zero or an unused base stops the timer
      if (tick & (tdiv_q != 8'h00) & (base_lim != 14'h0000)) begin
        if (base_cnt_q + 14'h0001 >= base_lim) begin
          base_cnt_q <= 14'h0000;
          if (div_cnt_q + 8'h01 >= tdiv_q) begin
            div_cnt_q   <= 8'h00;
            timer_pulse <= 1'b1;
          end else begin
            div_cnt_q <= div_cnt_q + 8'h01;
          end
        end else begin
          base_cnt_q <= base_cnt_q + 14'h0001;
        end
      end
    end
  end

  // ----------------------------------------
  // Channels, latching and snapshots
  // ----------------------------------------
  wire [71:0] cnt_all;
  wire [2:0]  ovf_all;
  wire [2:0]  cy_up;
  wire [2:0]  cy_dn;
  wire [2:0]  sw_latch;
  wire [71:0] snap_all;
  wire        casc48 = (clkcasc_q[3:2] == `QEC_CASC_48);

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_ch
      wire [2:0] src = latch_q[g*4 +: 3];
      wire       lc  = latch_q[g*4 + 3];
      wire       rd_hi = io_rd & (io_addr[3:2] == g) & (io_addr[1:0] == `QEC_SUB_HIGH);
      wire       rd_ov = io_rd & (io_addr[3:2] == g) & (io_addr[1:0] == `QEC_SUB_OVF);
      wire       ev = ((src == `QEC_LSRC_INDEX) & rise[g]) |
                      ((src == `QEC_LSRC_DI0)   & rise[3]) |
                      ((src == `QEC_LSRC_DI1)   & rise[4]) |
                      ((src == `QEC_LSRC_TIMER) & timer_pulse);
      assign sw_latch[g] = rd_hi & (src == `QEC_LSRC_SW);
      wire       cen = (g == 0) & (casc48 | (mode_q[2:0] == `QEC_MODE_CASCADE));
      reg [23:0] snap_q;

      always @(posedge ref_clk) begin
        if (rst)
          snap_q <= 24'h00_0000;
        else if (sw_latch[g] | ev)
          snap_q <= cnt_all[g*24 +: 24];
      end
      assign snap_all[g*24 +: 24] = snap_q;

      qec_chan u_chan (
        .ref_clk         (ref_clk),
        .rst             (rst),
        .samp            (samp_q),
        .enc_a           (a_s[g]),
        .enc_b           (b_s[g]),
        .input_mode_sel  (mode_q[g*4 +: 3]),
        .reset_value_sel (mode_q[g*4 + 3]),
        .wrap_en         (hold_q[g]),
        .clr             (clr_q[g] | ((ev | sw_latch[g]) & lc)),
        .casc_en         (cen),
        .casc_up         (cy_up[1]),
        .casc_dn         (cy_dn[1]),
        .ovf_clr         (rd_ov),
        .count_q         (cnt_all[g*24 +: 24]),
        .overflow_seen   (ovf_all[g]),
        .carry_up        (cy_up[g]),
        .carry_dn        (cy_dn[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Interrupt controller
  // ----------------------------------------
  wire [7:0] ic_src = {tbase_q[3] ? timer_pulse : rise[4], rise[3], rise[2:0], ovf_all};
  reg  [7:0] ovf_lvl_q;
  wire [7:0] ic_edge = {ic_src[7:3], ovf_all & ~ovf_lvl_q[2:0]};
  wire [7:0] ic_act = ic_pend_q & ~ic_mask_q;
  reg  [2:0] ic_sel;
  reg  [7:0] ic_ack_clr;
  integer    k;

  always @* begin
    ic_sel = 3'h0;
    for (k = 7; k >= 0; k = k - 1) begin
      if (ic_act[k])
        ic_sel = k[2:0];
    end
  end

  always @* begin
    ic_ack_clr = 8'h00;
    if (io_wr & (io_addr == `QEC_OFS_IC_PEND))
      ic_ack_clr = io_wdata;
    else if (io_rd & (io_addr == `QEC_OFS_IC_ACK) & (ic_act != 8'h00))
      ic_ack_clr[ic_sel] = 1'b1;
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      ic_pend_q <= 8'h00;
      ovf_lvl_q <= 8'h00;
      irq_q     <= 1'b0;
    end else begin
      ovf_lvl_q <= {5'h00, ovf_all};
      // New edges win over an acknowledge in the same cycle
      ic_pend_q <= (ic_pend_q & ~ic_ack_clr) | ic_edge;
      irq_q     <= (ic_act != 8'h00);
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  wire [23:0] cnt_sel  = cnt_all[io_addr[3:2]*24 +: 24];
  wire [23:0] snap_sel = snap_all[io_addr[3:2]*24 +: 24];
  wire        sw_sel   = (latch_q[io_addr[3:2]*4 +: 3] == `QEC_LSRC_SW);

  always @(posedge ref_clk) begin
    if (rst) begin
      io_rdata <= 8'h00;
    end else if (io_rd) begin
      if (io_addr < `QEC_OFS_IC_PEND) begin
        if (io_addr[1:0] == 2'h0)
          io_rdata <= snap_sel[7:0];
        else if (io_addr[1:0] == 2'h1)
          io_rdata <= snap_sel[15:8];
        else if (io_addr[1:0] == `QEC_SUB_HIGH)
          io_rdata <= sw_sel ? cnt_sel[23:16] : snap_sel[23:16];
        else
          io_rdata <= {ovf_all[io_addr[3:2]], 7'h00};
      end else if (io_addr == `QEC_OFS_IC_PEND) begin
        io_rdata <= ic_pend_q;
      end else if (io_addr == `QEC_OFS_IC_MASK) begin
        io_rdata <= ic_mask_q;
      end else if (io_addr == `QEC_OFS_STATUS) begin
        io_rdata <= {3'h0, di1_s, di0_s, idx_s};
      end else begin
        io_rdata <= (ic_act != 8'h00) ? `QEC_IC_VEC_BASE + {5'h00, ic_sel} :
                                        8'h00;
      end
    end
  end
endmodule // qec_top

// File: qec_props.sv
// Port-level assertions for the encoder counter port map
`timescale 1ns/1ps
module qec_props (
  input wire       ref_clk,
  input wire       rst,
  input wire [3:0] io_addr,
  input wire [7:0] io_wdata,
  input wire       io_wr,
  input wire       io_rd,
  input wire [7:0] io_rdata,
  input wire [2:0] enc_index,
  input wire       digital_in_zero,
  input wire       digital_in_one,
  input wire       irq_q
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  reg        mask_q;
  reg        lcfg_q;
  wire       rd_st = io_rd && io_addr == 4'he;
  wire       rd_ack = io_rd && io_addr == 4'hf;
  wire [4:0] pins = {digital_in_one, digital_in_zero, enc_index};

  // Mask stays all-ones until software touches it
  always @(posedge ref_clk)
    if (rst) mask_q <= 1'b0;
    else if (io_wr && io_addr == 4'hd) mask_q <= 1'b1;

  // Non-software latch sources may refresh the snapshot at any time
  always @(posedge ref_clk)
    if (rst) lcfg_q <= 1'b0;
    else if (io_wr && io_addr >= 4'h3 && io_addr <= 4'h5 && io_wdata[2:0] != 3'h0)
      lcfg_q <= 1'b1;

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_pins_still;
    $stable(pins) [*5];
  endsequence
  sequence s_quiet;
    !io_wr && !rd_ack;
  endsequence
  sequence s_mid_rd;
    io_rd && io_addr < 4'hc && io_addr[1:0] == 2'h1 && !lcfg_q;
  endsequence

  property p_hold; !io_rd |=> $stable(io_rdata); endproperty
  property p_st_zero; rd_st |=> io_rdata[7:5] == 3'h0; endproperty
  property p_ovf_byte;
    io_rd && io_addr < 4'hc && io_addr[1:0] == 2'h3 |=> io_rdata[6:0] == 7'h00;
  endproperty
  property p_st_pins; s_pins_still ##0 rd_st |=> io_rdata[4:0] == $past(pins); endproperty
  property p_ack_vec; rd_ack |=> io_rdata == 8'h00 || io_rdata[7:3] == 5'h01; endproperty
  property p_ack_irq; s_quiet ##1 (rd_ack && irq_q) |=> io_rdata[7:3] == 5'h01; endproperty
  property p_mask_quiet; !mask_q |-> !irq_q; endproperty
  property p_snap; s_mid_rd ##1 (s_mid_rd ##0 $stable(io_addr)) |=> $stable(io_rdata);
  endproperty

  a_hold: assert property (p_hold)
    else $error("read data moved without a read");
  a_st_zero: assert property (p_st_zero)
    else $error("status upper bits not zero");
  a_ovf_byte: assert property (p_ovf_byte)
    else $error("flag byte unused bits not zero");
  a_st_pins: assert property (p_st_pins)
    else $error("status byte does not follow pins");
  a_ack_vec: assert property (p_ack_vec)
    else $error("acknowledge read out of vector range");
  a_ack_irq: assert property (p_ack_irq)
    else $error("acknowledge read empty while irq high");
  a_mask_quiet: assert property (p_mask_quiet)
    else $error("irq raised with reset mask");
  a_snap: assert property (p_snap)
    else $error("snapshot byte changed between reads");
endmodule // qec_props

bind qec_top qec_props u_props (
  .ref_clk         (ref_clk),
  .rst             (rst),
  .io_addr         (io_addr),
  .io_wdata        (io_wdata),
  .io_wr           (io_wr),
  .io_rd           (io_rd),
  .io_rdata        (io_rdata),
  .enc_index       (enc_index),
  .digital_in_zero (digital_in_zero),
  .digital_in_one  (digital_in_one),
  .irq_q           (irq_q)
);

// File: qec_enc.sv
// Encoder pin model driving all three channels in step
`timescale 1ns/1ps
module qec_enc (
  input  wire       ref_clk,
  output reg  [2:0] enc_a,
  output reg  [2:0] enc_b,
  output reg  [2:0] enc_index
);
  reg [1:0] ph;

  initial begin
    ph = 2'h0;
    enc_a = 3'h0;
    enc_b = 3'h0;
    enc_index = 3'h0;
  end

  // Gray phase walk, A leading for up; 12 cycles per edge clears the slowest sampling
  task move(input integer n, input reg up);
    integer k;
    for (k = 0; k < 4 * n; k = k + 1) begin
      repeat (12) @(negedge ref_clk);
      ph = up ? ph + 2'h1 : ph - 2'h1;
      enc_a = {3{ph[1] ^ ph[0]}};
      enc_b = {3{ph[1]}};
    end
  endtask

  task idx(input [2:0] v);
    enc_index = v;
  endtask
endmodule // qec_enc

// File: qec_top_bench.sv
// Self-checking bench for the encoder counter port map
`timescale 1ns/1ps
module qec_top_bench;
  reg         ref_clk = 1'b0;
  reg         rst = 1'b1;
  reg  [3:0]  io_addr = 4'h0;
  reg  [7:0]  io_wdata = 8'h00;
  reg         io_wr = 1'b0;
  reg         io_rd = 1'b0;
  reg         digital_in_zero = 1'b0;
  reg         digital_in_one = 1'b0;
  wire [7:0]  io_rdata;
  wire [2:0]  enc_a;
  wire [2:0]  enc_b;
  wire [2:0]  enc_index;
  wire        irq_q;
  integer     failures = 0;
  integer     n_tests = 0;
  integer     i;
  integer     m;
  integer     n;
  reg  [7:0]  d;
  reg  [23:0] c;

  always #2.5 ref_clk = ~ref_clk;

  qec_top #(.TICK_CYCLES(10), .SAMP_CYCLES(2)) dut (
    .ref_clk(ref_clk), .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .enc_a(enc_a), .enc_b(enc_b),
    .enc_index(enc_index), .digital_in_zero(digital_in_zero),
    .digital_in_one(digital_in_one), .irq_q(irq_q));

  qec_enc enc (.ref_clk(ref_clk), .enc_a(enc_a), .enc_b(enc_b), .enc_index(enc_index));

  // ----------------------------------------
  // Bus tasks, entered at a falling edge
  // ----------------------------------------
  task chk(input string what, input [23:0] exp, input [23:0] got);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task pause(input integer k);
    io_rd = 1'b0;
    io_wr = 1'b0;
    repeat (k) @(negedge ref_clk);
  endtask
  task wr(input [3:0] a, input [7:0] v);
    io_rd = 1'b0;
    io_addr = a;
    io_wdata = v;
    io_wr = 1'b1;
    @(negedge ref_clk);
  endtask
  task rd(input [3:0] a, output [7:0] v);
    io_wr = 1'b0;
    io_addr = a;
    io_rd = 1'b1;
    @(negedge ref_clk);
    v = io_rdata;
  endtask
  // High byte first so the rest come from one snapshot
  task rd_cnt(input [3:0] ch, output [23:0] v);
    reg [7:0] b;
    rd(ch * 4'h4 + 4'h2, v[23:16]);
    rd(ch * 4'h4 + 4'h1, v[15:8]);
    rd(ch * 4'h4 + 4'h1, b);
    rd(ch * 4'h4, v[7:0]);
    pause(1);
    chk("mid repeat", v[15:8], b);
  endtask
  function [23:0] exp_delta(input integer md, input integer k);
    case (md)
      1, 5: exp_delta = k;
      2: exp_delta = 2 * k;
      3: exp_delta = 4 * k;
      default: exp_delta = 24'h0;
    endcase
  endfunction
  task wrap_up;
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Whole run is a few thousand cycles; ten times that means a hang
  initial begin
    #200000;
    failures = failures + 1;
    wrap_up;
  end

  initial begin
    n = $urandom(32'hda6a);
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    for (i = 0; i < 3; i = i + 1) begin
      rd_cnt(i[3:0], c);
      chk("count after reset", 24'h0, c);
      rd(i[3:0] * 4'h4 + 4'h3, d);
      chk("flag after reset", 8'h00, d);
    end
    wr(4'h6, 8'h07);
    for (m = 0; m < 6; m = m + 1) begin
      wr(4'h8, 8'($urandom_range(2, 0)));
      for (i = 0; i < 3; i = i + 1) wr(i[3:0], m[7:0]);
      wr(4'h7, 8'h07);
      pause(1);
      n = $urandom_range(9, 1);
      enc.move(n, 1'b1);
      pause(40);
      for (i = 0; i < 3; i = i + 1) begin
        rd_cnt(i[3:0], c);
        chk("count", exp_delta(m, n), c);
      end
    end
    wr(4'h0, 8'h08);
    wr(4'h7, 8'h01);
    pause(2);
    rd_cnt(4'h0, c);
    chk("middle reset", 24'h80_0000, c);
    wr(4'h0, 8'h03);
    wr(4'h6, 8'h06);
    wr(4'h7, 8'h01);
    pause(1);
    enc.move(1, 1'b0);
    pause(40);
    rd_cnt(4'h0, c);
    chk("held count", 24'h0, c);
    rd(4'h3, d);
    chk("overflow flag", 8'h80, d);
    rd(4'h3, d);
    chk("flag cleared", 8'h00, d);
    wr(4'h6, 8'h07);
    wr(4'h7, 8'h01);
    pause(1);
    enc.move(1, 1'b0);
    pause(40);
    wr(4'hb, 8'hff);
    pause(2);
    rd_cnt(4'h0, c);
    chk("wrapped count", 24'hff_fffc, c);
    rd(4'h2, d);
    pause(1);
    enc.move(1, 1'b1);
    pause(40);
    rd(4'h1, d);
    chk("mid from snapshot", 8'hff, d);
    rd(4'h0, d);
    chk("low from snapshot", 8'hfc, d);
    pause(1);
    wr(4'h8, 8'h04);
    wr(4'h1, 8'h01);
    wr(4'h7, 8'h03);
    pause(1);
    enc.move(2, 1'b0);
    pause(40);
    rd_cnt(4'h0, c);
    chk("cascade upper", 24'hff_ffff, c);
    rd_cnt(4'h1, c);
    chk("cascade lower", 24'hff_fffe, c);
    wr(4'h8, 8'h00);
    wr(4'h0, 8'h07);
    wr(4'h7, 8'h03);
    pause(1);
    enc.move(1, 1'b0);
    pause(40);
    rd_cnt(4'h0, c);
    chk("mode cascade upper", 24'hff_ffff, c);
    wr(4'h5, 8'h0a);
    wr(4'h7, 8'h04);
    pause(1);
    enc.move(2, 1'b1);
    pause(40);
    digital_in_zero = 1'b1;
    pause(5);
    enc.move(1, 1'b1);
    pause(40);
    rd_cnt(4'h2, c);
    chk("latched count", 24'h2, c);
    wr(4'h5, 8'h00);
    rd_cnt(4'h2, c);
    chk("count after latch", 24'h1, c);
    for (i = 0; i < 4; i = i + 1) begin
      d = 8'($urandom);
      enc.idx(d[2:0]);
      digital_in_zero = d[3];
      digital_in_one = d[4];
      pause(5);
      rd(4'he, c[7:0]);
      pause(1);
      chk("status", {3'h0, d[4:0]}, c[7:0]);
    end
    digital_in_zero = 1'b0;
    digital_in_one = 1'b0;
    pause(5);
    wr(4'hc, 8'hff);
    wr(4'hd, 8'hbf);
    pause(3);
    chk("irq idle", 24'h0, irq_q);
    digital_in_zero = 1'b1;
    digital_in_one = 1'b1;
    pause(8);
    chk("irq raised", 24'h1, irq_q);
    rd(4'hf, d);
    chk("vector", 8'h0e, d);
    rd(4'hf, d);
    chk("empty vector", 8'h00, d);
    rd(4'hc, d);
    chk("pending", 8'h80, d);
    wr(4'hc, 8'h80);
    rd(4'hc, d);
    chk("pending cleared", 8'h00, d);
    pause(2);
    chk("irq dropped", 24'h0, irq_q);
    wr(4'h9, 8'h08);
    wr(4'ha, 8'h02);
    wr(4'hd, 8'h7f);
    pause(1);
    for (i = 0; i < 100 && irq_q !== 1'b1; i = i + 1) @(negedge ref_clk);
    chk("timer irq", 24'h1, irq_q);
    rd(4'hf, d);
    chk("timer vector", 8'h0f, d);
    wr(4'ha, 8'h00);
    pause(2);
    wrap_up;
  end
endmodule // qec_top_bench
